// ---- app_path.v ----
`timescale 1ns/10ps
`include "app_defines.vh"
module app_path (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // axi4-lite write
    input wire [`APP_AW-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read
    input wire [`APP_AW-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // samples
    input wire smp_valid,
    input wire signed [15:0] smp_ch1,
    input wire signed [15:0] smp_ch2,
    input wire signed [15:0] smp_ch3,
    input wire signed [15:0] smp_temp,
    // results
    output reg [15:0] first_angle_q,
    output reg [15:0] second_angle_q,
    output reg [15:0] out1_q,
    output reg [15:0] out2_q,
    output reg out_valid_q,
    output reg mag_err_q,
    output reg mag_loss_q,
    output reg busy_q,
    // output encoder feed
    output reg [11:0] sent_fast1_q,
    output reg [11:0] sent_fast2_q,
    output reg [12:0] pwm_duty_q,
    input wire [3:0] slow_sel,
    output reg [15:0] slow_word_q,
    output reg slow_valid_q
);

localparam [7:0] S_IDLE = 8'h01, S_COMP = 8'h02, S_FILT = 8'h04, S_AMP = 8'h08;
localparam [7:0] S_LOAD = 8'h10, S_CORD = 8'h20, S_POST = 8'h40, S_LIN = 8'h80;

// ----------------
// helpers
// ----------------
function signed [15:0] sat16(input signed [55:0] v);
    sat16 = (v > 56'sh7fff) ? 16'sh7fff : (v < -56'sh8000) ? 16'sh8000 : v[15:0];
endfunction

function signed [19:0] poly(input signed [15:0] a0, input signed [15:0] a1,
                            input signed [15:0] a2, input signed [15:0] t);
    reg signed [31:0] t2;
    reg signed [47:0] s;
    begin
        t2 = (t * t) >>> `APP_Q15;
        s = a0 + ((a1 * t) >>> `APP_Q15) + ((a2 * t2) >>> `APP_Q15);
        poly = s[19:0];
    end
endfunction

function [15:0] atan_lut(input [3:0] i);
    case (i)
        4'h0: atan_lut = 16'h2000;
        4'h1: atan_lut = 16'h12e4;
        4'h2: atan_lut = 16'h09fb;
        4'h3: atan_lut = 16'h0511;
        4'h4: atan_lut = 16'h028b;
        4'h5: atan_lut = 16'h0146;
        4'h6: atan_lut = 16'h00a3;
        4'h7: atan_lut = 16'h0051;
        4'h8: atan_lut = 16'h0029;
        4'h9: atan_lut = 16'h0014;
        4'ha: atan_lut = 16'h000a;
        4'hb: atan_lut = 16'h0005;
        4'hc: atan_lut = 16'h0003;
        default: atan_lut = 16'h0001;
    endcase
endfunction

function [15:0] cfg_rst(input [6:0] i);
    case (i)
        `APP_R_LOSS: cfg_rst = `APP_LOSS_RST;
        `APP_R_MHIGH: cfg_rst = `APP_MHIGH_RST;
        `APP_R_TILT, `APP_R_PGAIN, `APP_R_PGAIN + 7'h1: cfg_rst = `APP_UNITY;
        `APP_R_GAIN, `APP_R_GAIN + 7'h3, `APP_R_GAIN + 7'h6: cfg_rst = `APP_UNITY;
        default: cfg_rst = 16'h0000;
    endcase
endfunction

// ----------------
// register file and axi4-lite slave
// ----------------
reg [15:0] cfg_q [0:`APP_NCFG-1];
reg aw_ok_q;
reg w_ok_q;
reg [6:0] widx_q;
reg [15:0] wdat_q;
reg [1:0] wstb_q;
reg [15:0] amp_q;
reg [31:0] rd_d;
reg rd_err_d;
wire [6:0] ridx = s_axi_araddr[`APP_AW-1:2];
integer k;

always @*
begin
    rd_err_d = 1'b0;
    rd_d = 32'h0000_0000;
    if (ridx < `APP_NCFG)
        rd_d = {16'h0000, cfg_q[ridx]};
    else
        case (ridx)
            `APP_R_ANG1: rd_d = {16'h0000, first_angle_q};
            `APP_R_ANG2: rd_d = {16'h0000, second_angle_q};
            `APP_R_OUT1: rd_d = {16'h0000, out1_q};
            `APP_R_OUT2: rd_d = {16'h0000, out2_q};
            `APP_R_AMP: rd_d = {16'h0000, amp_q};
            `APP_R_FLAG: rd_d = {29'h0, mag_loss_q, mag_err_q, busy_q};
            default: rd_err_d = 1'b1;
        endcase
end

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        for (k = 0; k < `APP_NCFG; k = k + 1)
            cfg_q[k] <= cfg_rst(k[6:0]); // RULE18
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `APP_OKAY;
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b0;
        s_axi_rresp <= `APP_OKAY;
        s_axi_rdata <= 32'h0000_0000;
        aw_ok_q <= 1'b0;
        w_ok_q <= 1'b0;
        widx_q <= 7'h00;
        wdat_q <= 16'h0000;
        wstb_q <= 2'h0;
    end
    else
    begin
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_ok_q <= 1'b1;
            widx_q <= s_axi_awaddr[`APP_AW-1:2];
            s_axi_awready <= 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_ok_q <= 1'b1;
            wdat_q <= s_axi_wdata[15:0];
            wstb_q <= s_axi_wstrb[1:0];
            s_axi_wready <= 1'b0;
        end
        if (aw_ok_q && w_ok_q && !s_axi_bvalid)
        begin
            aw_ok_q <= 1'b0;
            w_ok_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (widx_q < `APP_NCFG) ? `APP_OKAY : `APP_SLVERR;
            if (widx_q < `APP_NCFG)
            begin
                if (wstb_q[0])
                    cfg_q[widx_q][7:0] <= wdat_q[7:0];
                if (wstb_q[1])
                    cfg_q[widx_q][15:8] <= wdat_q[15:8];
            end
        end
        if (s_axi_bvalid && s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_d;
            s_axi_rresp <= rd_err_d ? `APP_SLVERR : `APP_OKAY;
        end
        if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
end

// ----------------
// datapath combinational terms
// ----------------
wire [15:0] path = cfg_q[`APP_R_PATH];
wire [15:0] proto = cfg_q[`APP_R_PROTO];
wire [1:0] mode = cfg_q[`APP_R_FRONT][`APP_MODE_LSB +: 2];
wire [1:0] modsel = cfg_q[`APP_R_FRONT][`APP_MOD_LSB +: 2];
wire two = (mode != `APP_M_ONE);
wire var_bp = path[`APP_VARBP]; // RULE17
reg signed [15:0] raw_q [0:2];
reg signed [15:0] cc_q [0:2];
reg signed [15:0] lp_q [0:2];
reg signed [15:0] ph_d [0:2];
reg signed [15:0] t_q;
reg signed [21:0] cx_q;
reg signed [21:0] cy_q;
reg [15:0] cz_q;
reg [3:0] it_q;
reg [1:0] jb_q;
reg signed [19:0] mag_q;
reg signed [15:0] sin1_q;
reg signed [15:0] sin2_q;
reg signed [15:0] lin1_q;
reg signed [15:0] dnc_q;
reg lch_q;
reg [5:0] li_q;
reg [7:0] st_q;

always @*
begin
    ph_d[0] = cc_q[0];
    ph_d[1] = sat16(cc_q[1] + ((cc_q[0] * $signed(cfg_q[`APP_R_PH2])) >>> `APP_Q15)); // RULE8
    ph_d[2] = sat16(cc_q[2] + ((cc_q[0] * $signed(cfg_q[`APP_R_PH3])) >>> `APP_Q15)); // RULE8
end

// cordic job selection
reg signed [21:0] jx;
reg signed [21:0] jy;
reg signed [31:0] kt_p;
reg signed [15:0] jc;
always @*
begin
    jx = lp_q[0];
    jy = lp_q[1];
    jc = jb_q[1] ? lp_q[2] : lp_q[1];
    kt_p = ($signed(cfg_q[`APP_R_TILT]) * (jb_q[1] ? lp_q[1] : lp_q[2])) >>> `APP_FRAC;
    if (mode == `APP_M_ATAN)
    begin
        jx = jb_q[0] ? lp_q[1] : lp_q[0]; // RULE1
        jy = lp_q[2];
    end
    else if (mode == `APP_M_TILT)
    begin
        if (!jb_q[0])
        begin
            jx = lp_q[0]; // RULE2
            jy = kt_p[21:0];
        end
        else
        begin
            jx = (jc < 0) ? -jc : jc;
            jy = (jc < 0) ? -mag_q : mag_q;
        end
    end
end

wire last_job = (mode == `APP_M_TILT) ? (jb_q == 2'h3) : (jb_q == {1'b0, two});
wire signed [33:0] amp_sum = (lp_q[0] * lp_q[0] + lp_q[1] * lp_q[1]
                             + (two ? lp_q[2] * lp_q[2] : 34'sh0)) >>> `APP_Q15;
wire signed [37:0] mag_p = cx_q * $signed({1'b0, `APP_CGAIN});
wire signed [19:0] zp = poly(cfg_q[`APP_R_ZERO], cfg_q[`APP_R_ZERO + 7'h1],
                            cfg_q[`APP_R_ZERO + 7'h2], t_q);
wire [15:0] z1 = first_angle_q - zp[15:0]; // RULE23
wire [15:0] z2 = second_angle_q - cfg_q[`APP_R_ZSEC]; // RULE12
reg [15:0] m1;
always @*
begin
    case (modsel) // RULE13
        `APP_MOD_180: m1 = {z1[14:0], 1'b0};
        `APP_MOD_120: m1 = z1 + {z1[14:0], 1'b0};
        `APP_MOD_90: m1 = {z1[13:0], 2'h0};
        default: m1 = z1;
    endcase
end

function signed [15:0] prelin(input signed [15:0] a, input signed [15:0] g,
                              input [2:0] nm, input signed [15:0] off);
    reg signed [55:0] p;
    begin
        p = a * g;
        p = p <<< nm; // RULE14
        prelin = sat16((p >>> `APP_FRAC) + off); // RULE15
    end
endfunction

// breakpoint interpolation
wire signed [15:0] s_cur = lch_q ? sin2_q : sin1_q;
wire [15:0] us = {~s_cur[15], s_cur[14:0]};
wire [5:0] nlast = two ? `APP_LAST2 : `APP_LAST1;
wire [6:0] base = (two && lch_q) ? `APP_NBP2 : 7'h00;
wire [5:0] fidx = two ? {2'h0, us[15:`APP_SH2]} : {1'b0, us[15:`APP_SH1]};
wire [5:0] idx = var_bp ? li_q : fidx;
wire [3:0] nsp = lch_q ? path[`APP_NSP2_LSB +: 4] : path[`APP_NSP1_LSB +: 4];
reg signed [17:0] x0;
reg signed [17:0] x1;
reg signed [17:0] y0;
reg signed [17:0] y1;
reg signed [55:0] dlt;
reg signed [15:0] lin_d;
always @*
begin
    if (var_bp)
    begin
        x0 = $signed(cfg_q[`APP_R_BPX + base + idx]);
        x1 = $signed(cfg_q[`APP_R_BPX + base + idx + 7'h1]);
    end
    else
    begin
        x0 = -18'sd32768 + ($signed({12'h0, idx}) <<< (two ? `APP_SH2 : `APP_SH1)); // RULE16
        x1 = x0 + (18'sd1 <<< (two ? `APP_SH2 : `APP_SH1));
    end
    y0 = x0 + $signed(cfg_q[`APP_R_BPY + base + idx]); // RULE18
    y1 = x1 + $signed(cfg_q[`APP_R_BPY + base + idx + 7'h1]);
    dlt = (y1 - y0) * (s_cur - x0);
    if (var_bp)
        lin_d = sat16(y0 + ((dlt <<< nsp) >>> `APP_YSH)); // RULE20
    else
        lin_d = sat16(y0 + (dlt >>> (two ? `APP_SH2 : `APP_SH1))); // RULE19
end

wire bp_step = var_bp && (two || !lch_q) && li_q < nlast - 6'h1 && s_cur >= x1;
// noise filter acts without delay on the fresh primary value
wire [7:0] nthr = cfg_q[`APP_R_NOISE][15:8];
wire [7:0] ncut = cfg_q[`APP_R_NOISE][7:0];
wire signed [16:0] nd = lin1_q - dnc_q;
wire signed [16:0] nabs = (nd < 0) ? -nd : nd;
wire signed [27:0] nstep = (nd * $signed({1'b0, ncut})) >>> 8;
wire signed [15:0] dnc_w = (cfg_q[`APP_R_NOISE] == 16'h0000 || nabs > $signed({9'h0, nthr}))
                           ? lin1_q : sat16(dnc_q + nstep); // RULE21
wire [15:0] o1b = out1_q ^ `APP_PI_ANG;
wire [15:0] o2b = out2_q ^ `APP_PI_ANG;

// ----------------
// sequencer
// ----------------
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        st_q <= S_IDLE;
        for (k = 0; k < 3; k = k + 1)
        begin
            raw_q[k] <= 16'sh0000;
            cc_q[k] <= 16'sh0000;
            lp_q[k] <= 16'sh0000;
        end
        t_q <= 16'sh0000;
        cx_q <= 22'sh0;
        cy_q <= 22'sh0;
        cz_q <= 16'h0000;
        it_q <= 4'h0;
        jb_q <= 2'h0;
        mag_q <= 20'sh0;
        sin1_q <= 16'sh0000;
        sin2_q <= 16'sh0000;
        lin1_q <= 16'sh0000;
        dnc_q <= 16'sh0000;
        lch_q <= 1'b0;
        li_q <= 6'h00;
        amp_q <= 16'h0000;
        first_angle_q <= 16'h0000;
        second_angle_q <= 16'h0000;
        out1_q <= 16'h0000;
        out2_q <= 16'h0000;
        out_valid_q <= 1'b0;
        mag_err_q <= 1'b0;
        mag_loss_q <= 1'b0;
        busy_q <= 1'b0;
        sent_fast1_q <= 12'h000;
        sent_fast2_q <= 12'h000;
        pwm_duty_q <= 13'h0000;
        slow_word_q <= 16'h0000;
        slow_valid_q <= 1'b0;
    end
    else
    begin
        out_valid_q <= 1'b0;
        slow_valid_q <= proto[`APP_SENT_EN] && proto[`APP_SLOW_EN]; // RULE4
        slow_word_q <= (proto[`APP_SENT_EN] && proto[`APP_SLOW_EN] && slow_sel < `APP_NUID)
                       ? cfg_q[`APP_R_UID + slow_sel] : 16'h0000; // RULE4
        // encoder feed follows the latest outputs
        sent_fast1_q <= (proto[`APP_SENT_LOSS] && mag_loss_q)
                        ? cfg_q[`APP_R_LOSS][11:0] : o1b[15:4]; // RULE7
        sent_fast2_q <= two ? o2b[15:4] : 12'h000; // RULE3
        if (mag_loss_q)
            pwm_duty_q <= proto[`APP_PWM2K] ? {1'b0, cfg_q[`APP_R_LOSS][11:0]}
                                            : cfg_q[`APP_R_LOSS][12:0]; // RULE6
        else
            pwm_duty_q <= proto[`APP_PWM2K] ? {1'b0, o1b[15:4]} : o1b[15:3];
        case (st_q)
            S_IDLE:
            begin
                if (smp_valid)
                begin
                    raw_q[0] <= smp_ch1;
                    raw_q[1] <= smp_ch2;
                    raw_q[2] <= smp_ch3;
                    t_q <= smp_temp;
                    busy_q <= 1'b1;
                    st_q <= S_COMP;
                end
            end
            S_COMP:
            begin
                for (k = 0; k < 3; k = k + 1)
                    cc_q[k] <= sat16(((raw_q[k] - poly(cfg_q[`APP_R_OFF + 3 * k],
                        cfg_q[`APP_R_OFF + 3 * k + 1], cfg_q[`APP_R_OFF + 3 * k + 2], t_q))
                        * poly(cfg_q[`APP_R_GAIN + 3 * k], cfg_q[`APP_R_GAIN + 3 * k + 1],
                        cfg_q[`APP_R_GAIN + 3 * k + 2], t_q)) >>> `APP_FRAC); // RULE10
                st_q <= S_FILT;
            end
            S_FILT:
            begin
                for (k = 0; k < 3; k = k + 1)
                    lp_q[k] <= (cfg_q[`APP_R_LPF][3:0] == 4'h0) ? ph_d[k] :
                        sat16(lp_q[k] + ((ph_d[k] - lp_q[k]) >>> cfg_q[`APP_R_LPF][3:0])); // RULE9
                st_q <= S_AMP;
            end
            S_AMP:
            begin
                amp_q <= (amp_sum > 34'sh0ffff) ? 16'hffff : amp_sum[15:0];
                jb_q <= 2'h0;
                st_q <= S_LOAD;
            end
            S_LOAD:
            begin
                cx_q <= (jx < 0) ? -jx : jx;
                cy_q <= (jx < 0) ? -jy : jy;
                cz_q <= (jx < 0) ? `APP_PI_ANG : 16'h0000;
                it_q <= 4'h0;
                st_q <= S_CORD;
            end
            S_CORD:
            begin
                if (cy_q >= 0)
                begin
                    cx_q <= cx_q + (cy_q >>> it_q);
                    cy_q <= cy_q - (cx_q >>> it_q);
                    cz_q <= cz_q + atan_lut(it_q);
                end
                else
                begin
                    cx_q <= cx_q - (cy_q >>> it_q);
                    cy_q <= cy_q + (cx_q >>> it_q);
                    cz_q <= cz_q - atan_lut(it_q);
                end
                it_q <= it_q + 4'h1;
                if (it_q == `APP_ITER)
                begin
                    if (mode == `APP_M_TILT && !jb_q[0])
                        mag_q <= mag_p[34:15]; // RULE2
                    else if ((mode == `APP_M_TILT) ? jb_q[1] : jb_q[0])
                        second_angle_q <= cz_q;
                    else
                        first_angle_q <= cz_q;
                    jb_q <= jb_q + 2'h1;
                    st_q <= last_job ? S_POST : S_LOAD;
                end
            end
            S_POST:
            begin
                mag_err_q <= (amp_q < cfg_q[`APP_R_MLOW]) || (amp_q > cfg_q[`APP_R_MHIGH]); // RULE5
                mag_loss_q <= amp_q < cfg_q[`APP_R_MLOW];
                sin1_q <= prelin(m1, cfg_q[`APP_R_PGAIN], path[`APP_NMUL1_LSB +: 3],
                                 cfg_q[`APP_R_POFF]);
                sin2_q <= two ? prelin(z2, cfg_q[`APP_R_PGAIN + 7'h1], path[`APP_NMUL2_LSB +: 3],
                                       cfg_q[`APP_R_POFF + 7'h1]) : 16'sh0000; // RULE15
                lch_q <= 1'b0;
                li_q <= 6'h00;
                st_q <= S_LIN;
            end
            S_LIN:
            begin
                if (bp_step)
                    li_q <= li_q + 6'h1;
                else if (!lch_q)
                begin
                    lin1_q <= lin_d;
                    li_q <= 6'h00;
                    lch_q <= 1'b1;
                end
                else
                begin
                    out2_q <= two ? lin_d : 16'h0000;
                    dnc_q <= dnc_w;
                    out1_q <= dnc_w; // RULE21
                    out_valid_q <= 1'b1;
                    busy_q <= 1'b0;
                    st_q <= S_IDLE;
                end
            end
            default: st_q <= S_IDLE;
        endcase
    end
end

endmodule

// ---- app_defines.vh ----
`ifndef APP_DEFINES_VH
`define APP_DEFINES_VH
// Contract
// RULE1: two-angle arctangent mode: first angle atan2(ch3, ch1), second atan2(ch3, ch2)
// RULE2: tilt mode: atan of root(chA^2 + (tilt gain * chB)^2) over remaining channel
// RULE3: both two-angle modes send the angle pair as two 12-bit fast channels
// RULE4: ten 16-bit user id words go out on the slow channel when enabled
// RULE5: field magnitude below low or above high limit raises a range error
// RULE6: magnet loss on pwm gives loss value duty, 12 bits at 2 kHz, else 13
// RULE7: sent with loss flag set sends loss value low 12 bits on magnet loss
// RULE8: phase fix of channels 2 and 3 against channel 1; zero changes nothing
// RULE9: one low-pass selection for all channels; zero disables the filter
// RULE10: per channel second-order temperature polynomials for offset and gain
// RULE11: software zeroes channel-3 offset and copies channel-1 gain in xz mode
// RULE12: primary zero shift by temperature polynomial, secondary by constant when active
// RULE13: primary angle wraps into 90, 120, 180 degree sub-ranges or full turn
// RULE14: 3-bit gain exponents at path setup [7:5] and [11:9], up to 128
// RULE15: pre-linearisation gain and offset; secondary ones only in two-angle modes
// RULE16: fixed breakpoints: 33 or 2x17, x equally spaced, only y programmable
// RULE17: path setup bit 0 makes breakpoint x and y both programmable
// RULE18: breakpoints 16-bit signed, x absolute, y relative to x, reset zero
// RULE19: output interpolated linearly between the two bracketing breakpoints
// RULE20: 4-bit slope exponents at [4:1] and [15:12] scale variable slopes
// RULE21: noise filter smooths only changes below threshold [15:8], cutoff [7:0]
// RULE22: software keeps threshold 0..255, cutoff below half rate, zero disables
// RULE23: zero shift wraps over the full signed 16-bit range
`define APP_AW 9
`define APP_NCFG 116
`define APP_R_PATH 7'h00
`define APP_R_NOISE 7'h01
`define APP_R_TILT 7'h02
`define APP_R_PROTO 7'h03
`define APP_R_FRONT 7'h04
`define APP_R_LPF 7'h05
`define APP_R_MLOW 7'h06
`define APP_R_MHIGH 7'h07
`define APP_R_LOSS 7'h08
`define APP_R_PH2 7'h09
`define APP_R_PH3 7'h0a
`define APP_R_OFF 7'h0b
`define APP_R_GAIN 7'h14
`define APP_R_ZERO 7'h1d
`define APP_R_ZSEC 7'h20
`define APP_R_PGAIN 7'h21
`define APP_R_POFF 7'h23
`define APP_R_UID 7'h25
`define APP_R_BPY 7'h30
`define APP_R_BPX 7'h52
`define APP_R_ANG1 7'h78
`define APP_R_ANG2 7'h79
`define APP_R_OUT1 7'h7a
`define APP_R_OUT2 7'h7b
`define APP_R_AMP 7'h7c
`define APP_R_FLAG 7'h7d
`define APP_VARBP 0
`define APP_NSP1_LSB 1
`define APP_NMUL1_LSB 5
`define APP_NMUL2_LSB 9
`define APP_NSP2_LSB 12
`define APP_MODE_LSB 0
`define APP_MOD_LSB 2
`define APP_SENT_EN 0
`define APP_SLOW_EN 1
`define APP_SENT_LOSS 2
`define APP_PWM2K 3
`define APP_M_ONE 2'h0
`define APP_M_ATAN 2'h1
`define APP_M_TILT 2'h2
`define APP_MOD_FULL 2'h0
`define APP_MOD_180 2'h1
`define APP_MOD_120 2'h2
`define APP_MOD_90 2'h3
`define APP_LOSS_RST 16'h0fad
`define APP_UNITY 16'h4000
`define APP_MHIGH_RST 16'hffff
`define APP_FRAC 14
`define APP_Q15 15
`define APP_ITER 4'hf
`define APP_CGAIN 16'h4dba
`define APP_PI_ANG 16'h8000
`define APP_NUID 4'ha
`define APP_NBP2 7'h11
`define APP_LAST1 6'h20
`define APP_LAST2 6'h10
`define APP_SH1 11
`define APP_SH2 12
`define APP_YSH 16
`define APP_OKAY 2'h0
`define APP_SLVERR 2'h2
`endif

// ---- app_path_sva.sv ----
`timescale 1ns/10ps
`include "app_defines.vh"
module app_path_sva (
    // clock and reset
    input logic aclk,
    input logic aresetn,
    // register bus
    input logic [`APP_AW-1:0] s_axi_awaddr,
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic [1:0] s_axi_bresp,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic [`APP_AW-1:0] s_axi_araddr,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic [1:0] s_axi_rresp,
    input logic s_axi_rvalid,
    // samples and results
    input logic smp_valid,
    input logic busy_q,
    input logic out_valid_q,
    input logic mag_err_q,
    input logic mag_loss_q,
    input logic [15:0] slow_word_q,
    input logic slow_valid_q
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_take;
        smp_valid && !busy_q;
    endsequence
    sequence s_wtake;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    a_wr_answer: assert property (s_wtake |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    a_wr_refuse: assert property (s_wtake and s_axi_awaddr[8:2] >= 7'h74 |-> ##2
        s_axi_bresp == `APP_SLVERR) else $error("bad write accepted");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[8:2] == 7'h7e
        |=> s_axi_rresp == `APP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read ok");
    a_loss_err: assert property (mag_loss_q |-> mag_err_q)
        else $error("loss without range error");
    a_slow_gate: assert property (slow_word_q != 16'h0 |-> slow_valid_q)
        else $error("slow word while disabled");
    a_out_pulse: assert property (out_valid_q |=> !out_valid_q)
        else $error("result pulse too long");
    a_sample_done: assert property (s_take |=> busy_q[*8] ##[1:300] out_valid_q)
        else $error("sample not finished");
endmodule

bind app_path app_path_sva u_sva (.*);

// ---- app_path_bench.sv ----
`timescale 1ns/10ps
`include "app_defines.vh"
module app_path_bench;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, smp_valid, out_valid_q, mag_err_q, mag_loss_q, busy_q, slow_valid_q;
    logic [`APP_AW-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb, slow_sel;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic signed [15:0] smp_ch1, smp_ch2, smp_ch3, smp_temp;
    logic [15:0] first_angle_q, second_angle_q, out1_q, out2_q, slow_word_q;
    logic [11:0] sent_fast1_q, sent_fast2_q;
    logic [12:0] pwm_duty_q;
    int error_cnt, tests_run, cyc;
    app_path dut (.*);
    // ----------------
    // checking and bus tasks
    // ----------------
    task chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task near(input logic [15:0] g, input logic [15:0] e);
        logic signed [15:0] d;
        d = g - e;
        tests_run++;
        if ((^g === 1'bx) || d > 16'sd32 || d < -16'sd32)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h near %h", $time, g, e);
        end
    endtask
    task wr(input logic [6:0] i, input logic [15:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= {i, 2'b00};
        s_axi_wdata <= {16'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do @(negedge aclk); while (!(s_axi_awready && s_axi_wready));
        @(posedge aclk);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
        chk(s_axi_bresp, er);
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask
    task rdchk(input logic [6:0] i, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= {i, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(negedge aclk); while (s_axi_arready !== 1'b1);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
        chk(s_axi_rdata, e);
        chk(s_axi_rresp, er);
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask
    task smp(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
        @(posedge aclk);
        smp_valid <= 1'b1;
        smp_ch1 <= a;
        smp_ch2 <= b;
        smp_ch3 <= c;
        @(posedge aclk);
        smp_valid <= 1'b0;
        do @(negedge aclk); while (out_valid_q !== 1'b1);
        @(negedge aclk);
    endtask
    // ----------------
    // scenarios
    // ----------------
    task t_regs;
        rdchk(`APP_R_PATH, 32'h0, `APP_OKAY);
        rdchk(`APP_R_LOSS, 32'h0fad, `APP_OKAY);
        rdchk(`APP_R_TILT, 32'h4000, `APP_OKAY);
        rdchk(`APP_R_NOISE, 32'h0, `APP_OKAY);
        rdchk(`APP_R_BPY + 7'h5, 32'h0, `APP_OKAY);
        wr(`APP_R_PATH, 16'hf0a5, `APP_OKAY);
        rdchk(`APP_R_PATH, 32'hf0a5, `APP_OKAY);
        wr(`APP_R_NOISE, 16'h2010, `APP_OKAY);
        rdchk(`APP_R_NOISE, 32'h2010, `APP_OKAY);
        wr(7'h74, 16'h1, `APP_SLVERR);
        rdchk(7'h7e, 32'h0, `APP_SLVERR);
        wr(`APP_R_PATH, 16'h0, `APP_OKAY);
        wr(`APP_R_NOISE, 16'h0, `APP_OKAY);
    endtask
    task t_angles;
        wr(`APP_R_FRONT, {14'h0, `APP_M_ATAN}, `APP_OKAY);
        smp(16'd1000, 16'd0, 16'd1000);
        near(first_angle_q, 16'h2000);
        near(second_angle_q, 16'h4000);
        near({4'h0, sent_fast2_q}, 16'h0c00);
        near(out1_q, 16'h2000);
        near(out2_q, 16'h4000);
        chk(mag_err_q, 1'b0);
        wr(`APP_R_FRONT, {14'h0, `APP_M_TILT}, `APP_OKAY);
        smp(16'd0, 16'd1000, 16'd1000);
        near(first_angle_q, 16'h2000);
        near(second_angle_q, 16'h2000);
        wr(`APP_R_MHIGH, 16'h1, `APP_OKAY);
        smp(16'd1000, 16'd0, 16'd1000);
        chk({mag_err_q, mag_loss_q}, 2'b10);
        wr(`APP_R_MHIGH, 16'hffff, `APP_OKAY);
    endtask
    task t_loss;
        wr(`APP_R_MLOW, 16'h7fff, `APP_OKAY);
        wr(`APP_R_LOSS, 16'h1abc, `APP_OKAY);
        wr(`APP_R_PROTO, 16'h5, `APP_OKAY);
        smp(16'd0, 16'd0, 16'd0);
        chk({mag_err_q, mag_loss_q}, 2'b11);
        chk(sent_fast1_q, 12'habc);
        chk(pwm_duty_q, 13'h1abc);
        wr(`APP_R_PROTO, 16'h8, `APP_OKAY);
        smp(16'd0, 16'd0, 16'd0);
        chk(pwm_duty_q, 13'h0abc);
        wr(`APP_R_MLOW, 16'h0, `APP_OKAY);
    endtask
    task t_slow;
        wr(`APP_R_UID + 7'h3, 16'h1234, `APP_OKAY);
        wr(`APP_R_PROTO, 16'h3, `APP_OKAY);
        @(posedge aclk);
        slow_sel <= 4'h3;
        repeat (2) @(negedge aclk);
        chk({slow_valid_q, slow_word_q}, 17'h11234);
        @(posedge aclk);
        slow_sel <= 4'ha;
        repeat (2) @(negedge aclk);
        chk(slow_word_q, 16'h0);
    endtask
    task end_of_test;
        $display("errors %0d comparisons %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ----------------
    // clock, timeout, main sequence
    // ----------------
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            end_of_test;
        end
    end
    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, smp_valid} = 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {smp_ch1, smp_ch2, smp_ch3, smp_temp} = '0;
        s_axi_wstrb = 4'h3;
        slow_sel = 4'h0;
        {error_cnt, tests_run, cyc} = '0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs;
        t_angles;
        t_loss;
        t_slow;
        end_of_test;
    end
endmodule
